// ==== core/sram_spi_front.sv ====
// serial command front end of a byte-organised static memory
// ****************************************
// Behaviour
// [R1] low select enables the device; high select means standby, nothing taken
// [R2] a write under way when select rises still completes
// [R3] serial output is high impedance whenever select is high
// [R4] host drives select low after power-up before any sequence
// [R5] instruction, address and data bits are taken on serial clock rise
// [R6] serial output changes only after a serial clock fall
// [R7] first bit is taken on first rising edge after select falls
// [R8] host keeps select low and pause high for a whole operation
// [R9] pause low mid-sequence suspends transfer and keeps the position
// [R10] pause acts at once with clock low, else at the next fall
// [R11] host keeps select low throughout a pause
// [R12] while paused, input and clock are ignored, output is high impedance
// [R13] host releases pause only while the serial clock is low
// [R14] pause low forces the output to high impedance at any moment
// [R15] after release the operation resumes at the very bit it stopped; the output stays high impedance until the next serial clock fall
// [R16] each sequence opens by shifting an eight-bit instruction
// [R17] instruction, address and data move most significant bit first
// [R18] code 03h reads memory, code 02h writes memory at the address
// [R19] code 05h returns status, code 01h loads status from next byte
// [R20] a 16-bit address follows; its three top bits are ignored
// [R21] page mode steps the pointer and wraps inside the 32-byte page
// [R22] burst mode steps the pointer across the array, 1FFFh to 0000h
// [R23] select rising ends the operation and abandons the sequence
// [R24] output drives only in memory or status read data phases
// ****************************************
`timescale 1ns/1ps
module sram_spi_front #(
  parameter int AW = sram_spi_pkg::ADDR_W,
  parameter int PW = sram_spi_pkg::PAGE_W
) (
  // system clock and reset
  input wire logic mclk,
  input wire logic rst,
  // serial link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic si,
  output logic so_out,
  output logic so_oe_n,
  // system side status
  output logic link_selected,
  output logic byte_written,
  output logic [1:0] cfg_mode
);

  // ****************************************
  // elaboration checks
  // ****************************************
  initial begin
    if (AW != sram_spi_pkg::ADDR_W || AW > sram_spi_pkg::ADDR_PHASE_BITS) begin
      $error("address width unsupported");
    end
    if (PW < 1 || PW >= AW) begin
      $error("page width must lie inside the address");
    end
  end

  // ****************************************
  // link domain state
  // ****************************************
  sram_spi_pkg::phase_t phase;
  logic [4:0] cnt;
  logic [15:0] sh;
  logic [AW-1:0] ptr;
  logic [7:0] tx;
  logic [7:0] status;
  logic wr_tog;
  logic st_tog;
  sram_spi_pkg::mem_wr_t wr;
  logic [AW-1:0] raddr;
  logic [7:0] rdata;
  logic [7:0] next_byte;
  logic [15:0] next_addr;

  // pointer step for the current mode
  function automatic logic [AW-1:0] step_ptr(input logic [AW-1:0] p,
                                             input logic [1:0] mode);
    logic [AW-1:0] r;
    r = p;
    case (mode)
      sram_spi_pkg::MODE_PAGE: begin
        r = {p[AW-1:PW], p[PW-1:0] + {{(PW-1){1'b0}}, 1'b1}}; // [R21]
      end
      sram_spi_pkg::MODE_BURST: begin
        r = p + {{(AW-1){1'b0}}, 1'b1}; // [R22]
      end
      default: begin
        r = p;
      end
    endcase
    return r;
  endfunction : step_ptr

  // status as seen by a status read
  function automatic logic [7:0] status_view(input logic [7:0] s);
    logic [7:0] v;
    v = 8'h00;
    v[sram_spi_pkg::ST_MODE_HI] = s[sram_spi_pkg::ST_MODE_HI];
    v[sram_spi_pkg::ST_MODE_LO] = s[sram_spi_pkg::ST_MODE_LO];
    v[sram_spi_pkg::ST_ONE_BIT] = 1'b1;
    v[sram_spi_pkg::ST_SPARE_BIT] = s[sram_spi_pkg::ST_SPARE_BIT];
    return v;
  endfunction : status_view

  logic [1:0] cur_mode;
  assign cur_mode = status[sram_spi_pkg::ST_MODE_HI:sram_spi_pkg::ST_MODE_LO];
  assign next_byte = {sh[6:0], si}; // [R17]
  assign next_addr = {sh[14:0], si}; // [R17]

  // ****************************************
  // storage
  // ****************************************
  always_comb begin
    raddr = step_ptr(ptr, cur_mode);
    if (phase == sram_spi_pkg::PH_ADDR) begin
      raddr = next_addr[AW-1:0]; // [R20]
    end
  end

  always_comb begin
    wr.en = 1'b0;
    wr.addr = ptr;
    wr.data = next_byte;
    if (hold_n && phase == sram_spi_pkg::PH_WDATA &&
        cnt == sram_spi_pkg::LAST_DATA_BIT) begin
      wr.en = 1'b1;
    end
  end

  sram_byte_store #(
    .AW(AW)
  ) u_store (
    .sck(sck),
    .wr(wr),
    .raddr(raddr),
    .rdata(rdata)
  );

  // ****************************************
  // sequence engine on the rising serial clock
  // ****************************************
  // select high clears the engine asynchronously, so a new frame always
  // starts at the instruction even if the clock stopped mid-byte
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      phase <= sram_spi_pkg::PH_CMD; // [R1] [R23]
      cnt <= 5'h00;
      sh <= 16'h0000;
      ptr <= '0;
      tx <= 8'h00;
    end else if (hold_n) begin // [R9] [R12]
      // first edge after select low lands here with cnt at zero
      sh <= next_addr; // [R5] [R7]
      cnt <= cnt + 5'h01;
      case (phase)
        sram_spi_pkg::PH_CMD: begin
          if (cnt == sram_spi_pkg::LAST_CMD_BIT) begin // [R16]
            cnt <= 5'h00;
            case (next_byte)
              sram_spi_pkg::CMD_MEM_READ,
              sram_spi_pkg::CMD_MEM_WRITE: begin
                phase <= sram_spi_pkg::PH_ADDR; // [R18]
              end
              sram_spi_pkg::CMD_STATUS_READ: begin
                phase <= sram_spi_pkg::PH_STRD; // [R19]
                tx <= status_view(status);
              end
              sram_spi_pkg::CMD_STATUS_WRITE: begin
                phase <= sram_spi_pkg::PH_STWR; // [R19]
              end
              default: begin
                phase <= sram_spi_pkg::PH_IGNORE;
              end
            endcase
          end
        end
        sram_spi_pkg::PH_ADDR: begin
          if (cnt == sram_spi_pkg::LAST_ADDR_BIT) begin
            cnt <= 5'h00;
            ptr <= next_addr[AW-1:0]; // [R20]
            // only the instruction's lowest bit is left, in sh bit 15 above the address
            if (sh[15] == sram_spi_pkg::CMD_MEM_READ[0]) begin
              phase <= sram_spi_pkg::PH_RDATA; // [R18]
              tx <= rdata;
            end else begin
              phase <= sram_spi_pkg::PH_WDATA; // [R18]
            end
          end
        end
        sram_spi_pkg::PH_WDATA: begin
          if (cnt == sram_spi_pkg::LAST_DATA_BIT) begin
            // the byte is stored on this same edge, so select rising
            // afterwards can never cut a write short
            cnt <= 5'h00;
            ptr <= step_ptr(ptr, cur_mode); // [R2] [R21] [R22]
          end
        end
        sram_spi_pkg::PH_RDATA: begin
          if (cnt == sram_spi_pkg::LAST_DATA_BIT) begin
            cnt <= 5'h00;
            ptr <= step_ptr(ptr, cur_mode); // [R21] [R22]
            tx <= rdata;
          end
        end
        sram_spi_pkg::PH_STRD: begin
          if (cnt == sram_spi_pkg::LAST_DATA_BIT) begin
            cnt <= 5'h00;
            tx <= status_view(status);
          end
        end
        sram_spi_pkg::PH_STWR: begin
          if (cnt == sram_spi_pkg::LAST_DATA_BIT) begin
            cnt <= 5'h00;
            phase <= sram_spi_pkg::PH_IGNORE;
          end
        end
        default: begin
          cnt <= 5'h00;
        end
      endcase
    end
  end

  // ****************************************
  // status register and crossing toggles
  // ****************************************
  // kept across frames, so only the system reset clears it
  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      status <= sram_spi_pkg::ST_RESET;
      st_tog <= 1'b0;
    end else if (!cs_n && hold_n && phase == sram_spi_pkg::PH_STWR &&
                 cnt == sram_spi_pkg::LAST_DATA_BIT) begin
      status <= next_byte; // [R19]
      st_tog <= ~st_tog;
    end
  end

  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      wr_tog <= 1'b0;
    end else if (!cs_n && wr.en) begin
      wr_tog <= ~wr_tog;
    end
  end

  // ****************************************
  // serial output on the falling serial clock
  // ****************************************
  logic drive_phase;
  assign drive_phase = (phase == sram_spi_pkg::PH_RDATA) ||
                       (phase == sram_spi_pkg::PH_STRD); // [R24]

  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      so_out <= 1'b0;
    end else if (hold_n) begin
      so_out <= tx[3'h7 - cnt[2:0]]; // [R6] [R15] [R17]
    end
  end

  // enable is forced off asynchronously by select or pause; the pause
  // cannot re-enable it, so after a release the drive returns at the
  // next falling edge
  always_ff @(negedge sck or posedge cs_n or negedge hold_n) begin
    if (cs_n || !hold_n) begin
      so_oe_n <= 1'b1; // [R3] [R10] [R12] [R14]
    end else begin
      so_oe_n <= ~drive_phase; // [R6] [R24]
    end
  end

  // ****************************************
  // system clock side
  // ****************************************
  logic [1:0] sel_sync;
  logic [2:0] wr_sync;
  logic [2:0] st_sync;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sel_sync <= 2'h0;
      link_selected <= 1'b0;
    end else begin
      sel_sync <= {sel_sync[0], ~cs_n};
      link_selected <= sel_sync[1];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_sync <= 3'h0;
      byte_written <= 1'b0;
    end else begin
      wr_sync <= {wr_sync[1:0], wr_tog};
      byte_written <= wr_sync[2] ^ wr_sync[1];
    end
  end

  // status is stable for a whole byte after its toggle, so it is
  // safe to sample once the toggle has been seen
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_sync <= 3'h0;
      cfg_mode <= sram_spi_pkg::ST_RESET[sram_spi_pkg::ST_MODE_HI:
                                         sram_spi_pkg::ST_MODE_LO];
    end else begin
      st_sync <= {st_sync[1:0], st_tog};
      if (st_sync[2] ^ st_sync[1]) begin
        cfg_mode <= cur_mode;
      end
    end
  end

endmodule : sram_spi_front

// ==== shared/sram_spi_pkg.sv ====
// shared constants and types for the serial memory front end
package sram_spi_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int ADDR_W = 13;
  localparam int PAGE_W = 5;
  localparam int ADDR_PHASE_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam logic [4:0] LAST_CMD_BIT = 5'h07;
  localparam logic [4:0] LAST_ADDR_BIT = 5'h0F;
  localparam logic [4:0] LAST_DATA_BIT = 5'h07;

  // ****************************************
  // instruction codes
  // ****************************************
  localparam logic [7:0] CMD_MEM_READ = 8'h03;
  localparam logic [7:0] CMD_MEM_WRITE = 8'h02;
  localparam logic [7:0] CMD_STATUS_READ = 8'h05;
  localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;

  // ****************************************
  // status register layout
  // ****************************************
  localparam int ST_MODE_HI = 7;
  localparam int ST_MODE_LO = 6;
  localparam int ST_ONE_BIT = 1;
  localparam int ST_SPARE_BIT = 0;
  localparam logic [7:0] ST_RESET = 8'h00;
  localparam logic [1:0] MODE_BYTE = 2'h0;
  localparam logic [1:0] MODE_PAGE = 2'h2;
  localparam logic [1:0] MODE_BURST = 2'h1;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } mem_wr_t;

  typedef enum logic [2:0] {
    PH_CMD,
    PH_ADDR,
    PH_WDATA,
    PH_RDATA,
    PH_STWR,
    PH_STRD,
    PH_IGNORE
  } phase_t;

endpackage : sram_spi_pkg

// ==== core/sram_byte_store.sv ====
// byte-wide flip-flop storage written on the serial clock, read combinationally
`timescale 1ns/1ps
module sram_byte_store #(
  parameter int AW = sram_spi_pkg::ADDR_W
) (
  // clock
  input wire logic sck,
  // write side
  input wire sram_spi_pkg::mem_wr_t wr,
  // read side, combinational
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);

  // ****************************************
  // storage
  // ****************************************
  logic [7:0] mem [0:(1<<AW)-1];

  initial begin
    if (AW != sram_spi_pkg::ADDR_W) begin
      $error("store width must match the write carrier");
    end
  end

  always_ff @(posedge sck) begin
    if (wr.en) begin
      mem[wr.addr] <= wr.data;
    end
  end

  assign rdata = mem[raddr];

endmodule : sram_byte_store

// ==== bench/sram_spi_front_assertions.sv ====
// port assertions for the serial memory front end
`timescale 1ns/1ps
module sram_spi_front_chk (
  // system
  input wire logic mclk,
  input wire logic rst,
  // link
  input wire logic sck,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic so_out,
  input wire logic so_oe_n,
  // system side
  input wire logic link_selected,
  input wire logic byte_written,
  input wire logic [1:0] cfg_mode
);
  // ****
  // checks, all sampled on the system clock
  // ****
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  a_standby_hiz: assert property (cs_n |-> so_oe_n)
    else $error("output driven while deselected");
  a_pause_hiz: assert property (!hold_n |-> so_oe_n)
    else $error("output driven while paused");
  a_out_on_low: assert property ($changed(so_out) && !cs_n |-> !sck)
    else $error("serial data moved with clock high");
  a_drive_after_fall: assert property
    ($fell(so_oe_n) |-> !sck && !cs_n && hold_n)
    else $error("drive began at a wrong moment");
  a_select_seen: assert property ((!cs_n)[*5] |-> link_selected)
    else $error("selection not reported");
  a_standby_seen: assert property (cs_n[*5] |-> !link_selected)
    else $error("standby not reported");
  a_write_pulse: assert property (byte_written |=> !byte_written)
    else $error("write pulse longer than one cycle");
  a_write_selected: assert property (byte_written |-> link_selected)
    else $error("write outside a selected sequence");
  a_mode_quiet: assert property (cs_n[*8] |-> $stable(cfg_mode))
    else $error("mode changed in standby");
  c_write: cover property (byte_written);
  c_drive: cover property (!so_oe_n);
  c_mode: cover property ($changed(cfg_mode));
endmodule : sram_spi_front_chk

bind sram_spi_front sram_spi_front_chk sram_spi_front_chk_inst (
  .mclk, .rst, .sck, .cs_n, .hold_n, .so_out, .so_oe_n,
  .link_selected, .byte_written, .cfg_mode);

// ==== bench/spi_host.sv ====
// host model driving the serial memory link
`timescale 1ns/1ps
module spi_host (
  // link outputs
  output logic sck,
  output logic cs_n,
  output logic hold_n,
  output logic si,
  // link inputs
  input wire logic so_out,
  input wire logic so_oe_n
);
  logic hz;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    hold_n = 1'b1;
    si = 1'b0;
    hz = 1'b0;
  end
  task automatic start();
    cs_n = 1'b0;
    #20;
  endtask : start
  // released data line shows the inverse of its last bit
  task automatic stop();
    #20 cs_n = 1'b1;
    si = ~si;
    #40;
  endtask : stop
  task automatic shift(input logic [7:0] tx, input bit hd,
      output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si = tx[i];
      if (hd && i == 3) begin
        hold_n = 1'b0;
        // clock and data wiggle while paused, to be ignored
        repeat (2) begin
          #20 sck = 1'b1;
          #20 sck = 1'b0;
          si = ~si;
        end
        hz = so_oe_n;
        hold_n = 1'b1;
        si = tx[i];
      end
      #20 sck = 1'b1;
      rx[i] = so_oe_n ? 1'bz : so_out;
      #40 sck = 1'b0;
      #20;
    end
  endtask : shift
endmodule : spi_host

// ==== bench/testbench.sv ====
// self-checking bench for the serial memory front end
`timescale 1ns/1ps
module testbench;
  logic mclk;
  logic rst;
  logic sck, cs_n, hold_n, si, so_out, so_oe_n;
  logic link_selected, byte_written;
  logic [1:0] cfg_mode;
  int fails;
  int comparisons;
  int writes;
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  always @(posedge mclk) if (byte_written === 1'b1) writes++;
  sram_spi_front sram_spi_front_inst (.mclk, .rst, .sck, .cs_n, .hold_n,
    .si, .so_out, .so_oe_n, .link_selected, .byte_written, .cfg_mode);
  spi_host spi_host_inst (.sck, .cs_n, .hold_n, .si, .so_out, .so_oe_n);
  // ****
  // helpers
  // ****
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want) begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check
  // one select period; address sent whenever op bit 1 is set, as for memory codes
  task automatic frame(input logic [7:0] op, input logic [15:0] a,
      input int n, input logic [15:0] d, input bit hd,
      output logic [15:0] q);
    logic [7:0] r;
    spi_host_inst.start();
    spi_host_inst.shift(op, 1'b0, r);
    if (op[1]) begin
      spi_host_inst.shift(a[15:8], 1'b0, r);
      spi_host_inst.shift(a[7:0], hd, r);
    end
    for (int k = 0; k < n; k++) begin
      spi_host_inst.shift(d[15-8*k -: 8], 1'b0, r);
      q[15-8*k -: 8] = r;
    end
    spi_host_inst.stop();
    repeat (10) @(posedge mclk);
  endtask : frame
  // ****
  // scenarios
  // ****
  task automatic status_rw();
    logic [15:0] q;
    frame(8'hff, 16'h0000, 1, 16'h0000, 1'b0, q);
    check(q[15:8], 8'hzz);
    frame(8'h01, 16'h0000, 1, 16'h8300, 1'b0, q);
    check({6'h00, cfg_mode}, 8'h02);
    check({7'h00, link_selected}, 8'h00);
    frame(8'h05, 16'h0000, 2, 16'h0000, 1'b0, q);
    check(q[15:8], 8'h83);
    check(q[7:0], 8'h83);
  endtask : status_rw
  task automatic page_wrap();
    logic [15:0] q;
    int w;
    w = writes;
    frame(8'h02, 16'he03f, 2, 16'h5ac3, 1'b0, q);
    check(8'(writes - w), 8'h02);
    frame(8'h01, 16'h0000, 1, 16'h0000, 1'b0, q);
    frame(8'h03, 16'h003f, 2, 16'h0000, 1'b0, q);
    check(q[15:8], 8'h5a);
    check(q[7:0], 8'h5a); // byte mode repeats the same byte
    frame(8'h03, 16'h0020, 1, 16'h0000, 1'b0, q);
    check(q[15:8], 8'hc3);
  endtask : page_wrap
  task automatic burst_wrap();
    logic [15:0] q;
    frame(8'h01, 16'h0000, 1, 16'h4000, 1'b0, q);
    check({6'h00, cfg_mode}, 8'h01);
    frame(8'h02, 16'h1fff, 2, 16'h1122, 1'b0, q);
    frame(8'h03, 16'hffff, 2, 16'h0000, 1'b0, q);
    check(q[15:8], 8'h11);
    check(q[7:0], 8'h22);
  endtask : burst_wrap
  // pause in mid address: clock pulses must not move the position
  task automatic hold_resume();
    logic [15:0] q;
    frame(8'h03, 16'h0000, 1, 16'h0000, 1'b1, q);
    check(q[15:8], 8'h22);
    check({7'h00, spi_host_inst.hz}, 8'h01);
  endtask : hold_resume
  task automatic results();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  initial begin
    fails = 0;
    comparisons = 0;
    writes = 0;
    rst = 1'b1;
    repeat (10) @(posedge mclk);
    #1 rst = 1'b0;
    @(posedge mclk);
    status_rw();
    page_wrap();
    burst_wrap();
    hold_resume();
    results();
  end
  // all frames take well under this span
  initial begin
    #200000;
    fails++;
    results();
  end
endmodule : testbench
